// *** lan_nvm_config_loader.sv ***
// Purpose: Loads station address, PCI init and PHY words from the LAN image
// Assumes: Reset requests are single-cycle pulses on ref_clk
// Notes:   Shared load covers words 0x00-0x02, 0x13-0x18 and 0x40-0x4A
//
// Functional notes
// - Station address goes to primary receive address
// - Byte one bit zero goes first
// - Shared words load on shared reset
// - PCI words 0x0A-0x10 load on PCI reset, only with a valid image
// - Aux power plus PM advertises D3cold wake
// - Wake_power_mgmt_enable drives PME support
// - Bit three allows single host subsystem write
// - Bit two suppresses I/O space request
// - Bit one loads subsystem identifiers
// - Bit zero loads device identifier
// - PHY words 0x40-0x4A load for power-up
// - Bad signature skips rest, restores station address and shared control defaults
`timescale 1ns/10ps
module lan_nvm_config_loader (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     shared_reset_load,
  input  wire logic                     pci_reset_load,
  output nvm_loader_pkg::nvm_req_t      nvm_req,
  input  wire logic                     rd_valid,
  input  wire logic [15:0]              rd_data,
  input  wire logic                     host_subsys_wr,
  input  wire logic [15:0]              host_subsys_data,
  output logic [47:0]                   primary_receive_address,
  output logic [15:0]                   shared_init_ctl,
  output logic [15:0]                   phy_cfg_word,
  output logic [3:0]                    phy_cfg_index,
  output logic                          phy_cfg_valid,
  output nvm_loader_pkg::pci_cfg_t      pci_cfg,
  output logic                          image_valid,
  output logic                          load_busy
);
  import nvm_loader_pkg::*;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SIGN   = 3'b001,
    ST_ADDR   = 3'b010,
    ST_SHARED = 3'b011,
    ST_PHY    = 3'b100,
    ST_PCI    = 3'b101
  } load_state_t;

  load_state_t state_ff;
  load_state_t nxt_state;
  logic [6:0]  waddr_ff;
  logic [6:0]  nxt_waddr;
  logic        issued_ff;
  logic        nxt_issued;
  logic        pci_pend_ff;
  logic        nxt_pci_pend;
  logic        valid_ff;
  logic        nxt_valid;
  logic [47:0] addr_ff;
  logic [47:0] nxt_addr;
  logic [15:0] shctl_ff;
  logic [15:0] nxt_shctl;
  logic [15:0] init_ff;
  logic [15:0] nxt_init;
  logic [15:0] ssid_ff;
  logic [15:0] nxt_ssid;
  logic [15:0] svid_ff;
  logic [15:0] nxt_svid;
  logic [15:0] did_ff;
  logic [15:0] nxt_did;
  logic        ssid_wr_used_ff;
  logic        nxt_ssid_wr_used;
  logic [15:0] phy_word_ff;
  logic [15:0] nxt_phy_word;
  logic [3:0]  phy_idx_ff;
  logic [3:0]  nxt_phy_idx;
  logic        phy_vld_ff;
  logic        nxt_phy_vld;

  logic        fetch_start;
  logic        fetch_done;
  logic [15:0] fetch_word;

  nvm_word_fetch u_fetch (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .start     (fetch_start),
    .word_addr (waddr_ff),
    .nvm_req   (nvm_req),
    .rd_valid  (rd_valid),
    .rd_data   (rd_data),
    .done      (fetch_done),
    .word_q    (fetch_word)
  );

  assign fetch_start = (state_ff != ST_IDLE) && !issued_ff;

  always_comb begin
    nxt_state        = state_ff;
    nxt_waddr        = waddr_ff;
    nxt_issued       = issued_ff;
    nxt_pci_pend     = pci_pend_ff | pci_reset_load;
    nxt_valid        = valid_ff;
    nxt_addr         = addr_ff;
    nxt_shctl        = shctl_ff;
    nxt_init         = init_ff;
    nxt_ssid         = ssid_ff;
    nxt_svid         = svid_ff;
    nxt_did          = did_ff;
    nxt_ssid_wr_used = ssid_wr_used_ff;
    nxt_phy_word     = phy_word_ff;
    nxt_phy_idx      = phy_idx_ff;
    nxt_phy_vld      = 1'b0;
    if (fetch_start) begin
      nxt_issued = 1'b1;
    end
    case (state_ff)
      ST_IDLE: begin
        if (shared_reset_load) begin
          nxt_state = ST_SIGN;
          nxt_waddr = WORD_SHARED_CTL;
        end else if (pci_pend_ff) begin
          nxt_pci_pend = pci_reset_load;
          if (valid_ff) begin
            nxt_state = ST_PCI;
            nxt_waddr = WORD_PCI_INIT;
            nxt_ssid_wr_used = 1'b0;
          end
        end
      end
      ST_SIGN: begin
        if (fetch_done) begin
          nxt_issued = 1'b0;
          if (fetch_word[SIGN_HI:SIGN_LO] == SIGN_VALID) begin
            nxt_valid = 1'b1;
            nxt_state = ST_ADDR;
            nxt_waddr = WORD_ADDR_0;
          end else begin
            nxt_valid = 1'b0;
            nxt_state = ST_IDLE;
            nxt_addr  = DEF_STATION;
            nxt_shctl = SHARED_CTL_RST;
          end
        end
      end
      ST_ADDR: begin
        if (fetch_done) begin
          nxt_issued = 1'b0;
          // Word n holds bytes 2n+2 (high) and 2n+1 (low); byte 1 in bits 7:0
          nxt_addr[{waddr_ff[1:0], 4'h0} +: 16] = fetch_word;
          if (waddr_ff == WORD_ADDR_0 + 7'h02) begin
            nxt_state = ST_SHARED;
            nxt_waddr = WORD_SHARED_CTL;
          end else begin
            nxt_waddr = waddr_ff + 7'h01;
          end
        end
      end
      ST_SHARED: begin
        if (fetch_done) begin
          nxt_issued = 1'b0;
          if (waddr_ff == WORD_SHARED_CTL) begin
            nxt_shctl = fetch_word;
          end
          if (waddr_ff == WORD_SHARED_END) begin
            nxt_state   = ST_PHY;
            nxt_waddr   = WORD_PHY_FIRST;
            nxt_phy_idx = 4'h0;
          end else begin
            nxt_waddr = waddr_ff + 7'h01;
          end
        end
      end
      ST_PHY: begin
        if (fetch_done) begin
          nxt_issued   = 1'b0;
          nxt_phy_word = fetch_word;
          nxt_phy_idx  = 4'(waddr_ff - WORD_PHY_FIRST);
          nxt_phy_vld  = 1'b1;
          if (waddr_ff == WORD_PHY_LAST) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_waddr = waddr_ff + 7'h01;
          end
        end
      end
      ST_PCI: begin
        if (fetch_done) begin
          nxt_issued = 1'b0;
          if (waddr_ff == WORD_PCI_INIT) begin
            nxt_init = fetch_word;
            nxt_ssid = DEF_SUBSYS_ID;
            nxt_svid = DEF_SUBSYS_VID;
            nxt_did  = DEF_DEVICE_ID;
          end else if (waddr_ff == WORD_SUBSYS_ID && init_ff[BIT_LOAD_SUBSYS]) begin
            nxt_ssid = fetch_word;
          end else if (waddr_ff == WORD_SUBSYS_VID && init_ff[BIT_LOAD_SUBSYS]) begin
            nxt_svid = fetch_word;
          end else if (waddr_ff == WORD_DEVICE_ID && init_ff[BIT_LOAD_DEVID]) begin
            nxt_did = fetch_word;
          end
          if (waddr_ff == WORD_PCI_LAST) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_waddr = waddr_ff + 7'h01;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Taken host write wins over the re-arm in the same cycle
    if (host_subsys_wr && init_ff[BIT_SSID_WR1] && !ssid_wr_used_ff) begin
      nxt_ssid         = host_subsys_data;
      nxt_ssid_wr_used = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff        <= ST_IDLE;
      waddr_ff        <= 7'h00;
      issued_ff       <= 1'b0;
      pci_pend_ff     <= 1'b0;
      valid_ff        <= 1'b0;
      addr_ff         <= DEF_STATION;
      shctl_ff        <= SHARED_CTL_RST;
      init_ff         <= PCI_INIT_RST;
      ssid_ff         <= DEF_SUBSYS_ID;
      svid_ff         <= DEF_SUBSYS_VID;
      did_ff          <= DEF_DEVICE_ID;
      ssid_wr_used_ff <= 1'b0;
      phy_word_ff     <= 16'h0000;
      phy_idx_ff      <= 4'h0;
      phy_vld_ff      <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      waddr_ff        <= nxt_waddr;
      issued_ff       <= nxt_issued;
      pci_pend_ff     <= nxt_pci_pend;
      valid_ff        <= nxt_valid;
      addr_ff         <= nxt_addr;
      shctl_ff        <= nxt_shctl;
      init_ff         <= nxt_init;
      ssid_ff         <= nxt_ssid;
      svid_ff         <= nxt_svid;
      did_ff          <= nxt_did;
      ssid_wr_used_ff <= nxt_ssid_wr_used;
      phy_word_ff     <= nxt_phy_word;
      phy_idx_ff      <= nxt_phy_idx;
      phy_vld_ff      <= nxt_phy_vld;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign primary_receive_address           = addr_ff;
  assign shared_init_ctl                   = shctl_ff;
  assign phy_cfg_word                      = phy_word_ff;
  assign phy_cfg_index                     = phy_idx_ff;
  assign phy_cfg_valid                     = phy_vld_ff;
  assign image_valid                       = valid_ff;
  assign load_busy                         = (state_ff != ST_IDLE);
  assign pci_cfg.aux_power_indication      = init_ff[BIT_AUX_POWER];
  assign pci_cfg.wake_power_mgmt_enable    = init_ff[BIT_PM_ENA];
  assign pci_cfg.pme_d3cold_support        = init_ff[BIT_AUX_POWER] & init_ff[BIT_PM_ENA];
  assign pci_cfg.subsys_id_host_write_once = init_ff[BIT_SSID_WR1] & ~ssid_wr_used_ff;
  assign pci_cfg.io_bar_request            = ~init_ff[BIT_IO_BAR_DIS];
  assign pci_cfg.subsys_id                 = ssid_ff;
  assign pci_cfg.subsys_vendor_id          = svid_ff;
  assign pci_cfg.device_id                 = did_ff;
endmodule

// *** lan_nvm_config_loader_properties.sv ***
// Purpose: Port-level checks for the LAN image configuration loader
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to every instance of the loader
`timescale 1ns/10ps
module lan_nvm_config_loader_checker
  import nvm_loader_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        shared_reset_load,
  input nvm_req_t         nvm_req,
  input wire logic        rd_valid,
  input wire logic [47:0] primary_receive_address,
  input wire logic        phy_cfg_valid,
  input pci_cfg_t         pci_cfg,
  input wire logic        image_valid,
  input wire logic        load_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------
  // Word handshake sequences
  // --------------------------------------------------------------
  sequence s_wait;
    nvm_req.req && !rd_valid;
  endsequence
  sequence s_done;
    nvm_req.req && rd_valid;
  endsequence
  sequence s_phy_done;
    s_done ##0 (nvm_req.byte_addr >= 8'h80 && nvm_req.byte_addr <= 8'h94);
  endsequence
  a_req_hold: assert property (s_wait |=> nvm_req.req && $stable(nvm_req.byte_addr))
    else $error("request dropped or moved before answer");
  a_addr_even: assert property (nvm_req.req |-> !nvm_req.byte_addr[0])
    else $error("odd image byte address");
  a_req_gap: assert property (s_done |=> !nvm_req.req)
    else $error("request not released after answer");
  a_first_sign: assert property (shared_reset_load && !load_busy
    |-> ##[1:3] (nvm_req.req && nvm_req.byte_addr == 8'h26))
    else $error("shared load did not start at control word");
  a_pci_gated: assert property (nvm_req.req && nvm_req.byte_addr >= 8'h14
    && nvm_req.byte_addr <= 8'h20 |-> image_valid)
    else $error("PCI word read without valid image");
  a_d3cold_adv: assert property (pci_cfg.pme_d3cold_support
    == (pci_cfg.aux_power_indication && pci_cfg.wake_power_mgmt_enable))
    else $error("D3cold wake advertisement wrong");
  a_phy_emit: assert property (s_phy_done |-> ##[0:2] phy_cfg_valid)
    else $error("PHY word not presented");
  a_phy_pulse: assert property (phy_cfg_valid |=> !phy_cfg_valid)
    else $error("PHY valid longer than one cycle");
  a_addr_hold: assert property (!load_busy && $past(!load_busy)
    |-> $stable(primary_receive_address))
    else $error("station address changed while idle");
endmodule
bind lan_nvm_config_loader lan_nvm_config_loader_checker u_chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .shared_reset_load(shared_reset_load), .nvm_req(nvm_req),
  .rd_valid(rd_valid), .primary_receive_address(primary_receive_address),
  .phy_cfg_valid(phy_cfg_valid), .pci_cfg(pci_cfg), .image_valid(image_valid),
  .load_busy(load_busy));

// *** lan_nvm_config_loader_tb.sv ***
// Purpose: Self-checking bench for the LAN image configuration loader
// Assumes: Image model answers promptly or slowly
// Notes:   Expected values come from the bench's own image bytes
`timescale 1ns/10ps
module lan_nvm_config_loader_tb;
  import nvm_loader_pkg::*;
  logic        ref_clk, rst_n, shared_reset_load, pci_reset_load, rd_valid, slow;
  logic        host_subsys_wr, image_valid, load_busy, phy_cfg_valid;
  logic [15:0] rd_data, host_subsys_data, shared_init_ctl, phy_cfg_word, iw;
  logic [47:0] primary_receive_address, exp_addr, kept_addr;
  logic [3:0]  phy_cfg_index;
  logic [7:0]  sa [0:5];
  logic [7:0]  tbl [0:5] = '{8'hC3, 8'h0C, 8'h4A, 8'h85, 8'hCF, 8'h00};
  nvm_req_t    nvm_req;
  pci_cfg_t    pci_cfg, exp_pci, def_pci;
  logic [19:0] phy_q [$];
  int          num_errors, samples_checked;
  lan_nvm_config_loader u_lan_nvm_config_loader (.ref_clk(ref_clk), .rst_n(rst_n),
    .shared_reset_load(shared_reset_load), .pci_reset_load(pci_reset_load),
    .nvm_req(nvm_req), .rd_valid(rd_valid), .rd_data(rd_data),
    .host_subsys_wr(host_subsys_wr), .host_subsys_data(host_subsys_data),
    .primary_receive_address(primary_receive_address), .shared_init_ctl(shared_init_ctl),
    .phy_cfg_word(phy_cfg_word), .phy_cfg_index(phy_cfg_index),
    .phy_cfg_valid(phy_cfg_valid), .pci_cfg(pci_cfg), .image_valid(image_valid),
    .load_busy(load_busy));
  nvm_image_model u_img (.ref_clk(ref_clk), .rst_n(rst_n), .nvm_req(nvm_req), .slow(slow),
    .rd_valid(rd_valid), .rd_data(rd_data));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (phy_cfg_valid === 1'b1) phy_q.push_back({phy_cfg_index, phy_cfg_word});
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge ref_clk);
    while (load_busy !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) check("idle wait", 1, 0);
  endtask
  // ------------------------------------------------------------
  // Image build and expected values
  // ------------------------------------------------------------
  task automatic build(logic [1:0] sig, logic [7:0] low);
    logic [15:0] ck;
    for (int w = 0; w < 128; w++) u_img.mem[w] = 16'($urandom);
    for (int b = 0; b < 6; b++) sa[b] = 8'($urandom);
    sa[0][1:0] = 2'b00;
    for (int n = 0; n < 3; n++) u_img.mem[n] = {sa[2*n+1], sa[2*n]};
    for (int b = 0; b < 6; b++) exp_addr[8*b +: 8] = sa[b];
    u_img.mem[19][15:14] = sig;
    iw = {8'h10, low[7:6], 2'b00, low[3:0]};
    u_img.mem[10] = iw;
    // Checksum word keeps the word sum over the image head at zero
    ck = 16'h0000;
    for (int w = 0; w < 63; w++) ck = ck + u_img.mem[w];
    u_img.mem[63] = 16'h0000 - ck;
    exp_pci = '{iw[7], iw[6], iw[7] & iw[6], iw[3], !iw[2],
      iw[1] ? u_img.mem[11] : DEF_SUBSYS_ID, iw[1] ? u_img.mem[12] : DEF_SUBSYS_VID,
      iw[0] ? u_img.mem[13] : DEF_DEVICE_ID};
  endtask
  task automatic pulse(bit pci);
    @(posedge ref_clk);
    if (pci) pci_reset_load <= 1'b1;
    else shared_reset_load <= 1'b1;
    @(posedge ref_clk);
    pci_reset_load    <= 1'b0;
    shared_reset_load <= 1'b0;
  endtask
  task automatic host_write(logic [15:0] d);
    @(posedge ref_clk);
    host_subsys_wr   <= 1'b1;
    host_subsys_data <= d;
    @(posedge ref_clk);
    host_subsys_wr   <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  initial begin
    logic [15:0] d1;
    {rst_n, shared_reset_load, pci_reset_load, host_subsys_wr, slow} = '0;
    host_subsys_data = 16'h0000;
    void'($urandom(32'hd032a581));
    def_pci = '{PCI_INIT_RST[7], PCI_INIT_RST[6], PCI_INIT_RST[7] & PCI_INIT_RST[6],
      PCI_INIT_RST[3], !PCI_INIT_RST[2], DEF_SUBSYS_ID, DEF_SUBSYS_VID, DEF_DEVICE_ID};
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    check("addr rst", primary_receive_address, DEF_STATION);
    check("pci rst", pci_cfg, def_pci);
    $display("test reset done");
    build(2'b01, 8'hC3);
    pulse(0);
    wait_idle();
    check("valid bad", image_valid, 0);
    check("addr bad", primary_receive_address, DEF_STATION);
    check("ctl bad", shared_init_ctl, SHARED_CTL_RST);
    pulse(1);
    wait_idle();
    check("pci refused", pci_cfg.device_id, DEF_DEVICE_ID);
    $display("test bad signature done");
    build(2'b10, 8'hC3);
    slow <= 1'b1;
    phy_q.delete();
    pulse(0);
    wait_idle();
    wait_idle();
    check("valid", image_valid, 1);
    check("addr", primary_receive_address, exp_addr);
    check("ctl", shared_init_ctl, u_img.mem[19]);
    check("phy count", phy_q.size(), 11);
    for (int k = 0; k < 11 && k < phy_q.size(); k++)
      check("phy word", phy_q[k], {4'(k), u_img.mem[64+k]});
    check("pci pending", pci_cfg, def_pci);
    kept_addr = exp_addr;
    $display("test good image done");
    for (int i = 0; i < 6; i++) begin
      build(2'b10, tbl[i]);
      slow <= 1'($urandom);
      pulse(1);
      wait_idle();
      check("pci cfg", pci_cfg, exp_pci);
      check("addr kept", primary_receive_address, kept_addr);
      d1 = 16'($urandom);
      host_write(d1);
      check("host wr", pci_cfg.subsys_id, iw[3] ? d1 : exp_pci.subsys_id);
      check("wr once", pci_cfg.subsys_id_host_write_once, 0);
      host_write(~d1);
      check("host wr2", pci_cfg.subsys_id, iw[3] ? d1 : exp_pci.subsys_id);
      $display("test init word %h done", iw);
    end
    conclude();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end
endmodule

// *** nvm_image_model.sv ***
// Purpose: Behavioural image store answering word reads
// Assumes: Testbench fills mem before each load
// Notes:   Data line toggles whenever no word is presented
`timescale 1ns/10ps
module nvm_image_model
  import nvm_loader_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  nvm_req_t         nvm_req,
  input  wire logic        slow,
  output logic             rd_valid,
  output logic [15:0]      rd_data
);
  logic [15:0] mem [0:127];
  int          cnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
      cnt      <= 0;
    end else if (rd_valid) begin
      rd_valid <= 1'b0;
      rd_data  <= ~rd_data;
    end else if (nvm_req.req && cnt >= (slow ? 5 : 0)) begin
      rd_valid <= 1'b1;
      rd_data  <= mem[nvm_req.byte_addr[7:1]];
      cnt      <= 0;
    end else begin
      cnt      <= nvm_req.req ? cnt + 1 : 0;
      rd_data  <= ~rd_data;
    end
  end
endmodule

// *** nvm_loader_pkg.sv ***
// Purpose: Shared constants and carriers for the LAN image configuration loader
// Assumes: 16-bit image words, byte offset = 2 * word offset
// Notes:   Identifier defaults are arbitrary neutral values
package nvm_loader_pkg;

  localparam logic [6:0]  WORD_ADDR_0     = 7'h00;
  localparam logic [6:0]  WORD_PCI_INIT   = 7'h0A;
  localparam logic [6:0]  WORD_SUBSYS_ID  = 7'h0B;
  localparam logic [6:0]  WORD_SUBSYS_VID = 7'h0C;
  localparam logic [6:0]  WORD_DEVICE_ID  = 7'h0D;
  localparam logic [6:0]  WORD_PCI_LAST   = 7'h10;
  localparam logic [6:0]  WORD_SHARED_CTL = 7'h13;
  localparam logic [6:0]  WORD_SHARED_END = 7'h18;
  localparam logic [6:0]  WORD_PHY_FIRST  = 7'h40;
  localparam logic [6:0]  WORD_PHY_LAST   = 7'h4A;
  localparam logic [3:0]  PHY_WORDS       = 4'hB;

  localparam int          BIT_AUX_POWER   = 7;
  localparam int          BIT_PM_ENA      = 6;
  localparam int          BIT_SSID_WR1    = 3;
  localparam int          BIT_IO_BAR_DIS  = 2;
  localparam int          BIT_LOAD_SUBSYS = 1;
  localparam int          BIT_LOAD_DEVID  = 0;
  localparam int          SIGN_HI         = 15;
  localparam int          SIGN_LO         = 14;
  localparam logic [1:0]  SIGN_VALID      = 2'h2;

  localparam logic [15:0] PCI_INIT_RST    = 16'h10C3;
  localparam logic [15:0] SHARED_CTL_RST  = 16'hA505;
  // Arbitrary neutral identifier defaults
  localparam logic [15:0] DEF_SUBSYS_ID   = 16'h0000;
  localparam logic [15:0] DEF_SUBSYS_VID  = 16'h1234;
  localparam logic [15:0] DEF_DEVICE_ID   = 16'h5678;
  localparam logic [47:0] DEF_STATION     = 48'h0000_0000_0000;

  typedef struct packed {
    logic        aux_power_indication;
    logic        wake_power_mgmt_enable;
    logic        pme_d3cold_support;
    logic        subsys_id_host_write_once;
    logic        io_bar_request;
    logic [15:0] subsys_id;
    logic [15:0] subsys_vendor_id;
    logic [15:0] device_id;
  } pci_cfg_t;

  typedef struct packed {
    logic        req;
    logic [7:0]  byte_addr;
  } nvm_req_t;

endpackage

// *** nvm_word_fetch.sv ***
// Purpose: Issues one image word read and returns the word
// Assumes: Read data returns with rd_valid on the ref_clk domain
// Notes:   Byte address is twice the word address
`timescale 1ns/10ps
module nvm_word_fetch (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     start,
  input  wire logic [6:0]               word_addr,
  output nvm_loader_pkg::nvm_req_t      nvm_req,
  input  wire logic                     rd_valid,
  input  wire logic [15:0]              rd_data,
  output logic                          done,
  output logic [15:0]                   word_q
);
  import nvm_loader_pkg::*;

  logic        busy_ff;
  logic        nxt_busy;
  logic [7:0]  addr_ff;
  logic [7:0]  nxt_addr;
  logic [15:0] word_ff;
  logic [15:0] nxt_word;
  logic        done_ff;
  logic        nxt_done;

  // Word and done are registered, one cycle after rd_valid
  always_comb begin
    nxt_done = busy_ff && rd_valid;
    nxt_busy = busy_ff;
    nxt_addr = addr_ff;
    nxt_word = word_ff;
    if (start && !busy_ff) begin
      nxt_busy = 1'b1;
      nxt_addr = {word_addr, 1'b0};
    end else if (busy_ff && rd_valid) begin
      nxt_busy = 1'b0;
      nxt_word = rd_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      addr_ff <= 8'h00;
      word_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      addr_ff <= nxt_addr;
      word_ff <= nxt_word;
      done_ff <= nxt_done;
    end
  end

  assign nvm_req.req       = busy_ff;
  assign nvm_req.byte_addr = addr_ff;
  assign done              = done_ff;
  assign word_q            = word_ff;
endmodule
